// *** hw/dsc_deep_sleep_ctrl.v ***
// Purpose: deep-sleep control and status registers with wake-source capture
// Assumes: CPU reaches registers over a strobe port; read data one cycle later
// Notes:   RESET is the power-on reset; other resets come in on SYS_RESET_PULSE
//
// Function
// - With the arm bit set, a sleep request with no access since the arming write enters deep sleep, otherwise ordinary sleep.
// - Hardware sets the brown-out flag only when detection is enabled and a brown-out hits in deep sleep.
// - A brown-out in deep sleep only updates the flag and the brown-out interrupt status, and never wakes the device.
// - While the hold bit is 1 the pins keep their state; clearing it hands pins back.
// - Control bits 14 down to 2 always read as zero.
// - The program-memory sleep-power bit decides power-down in ordinary sleep; deep sleep always powers down; regulator standby follows it.
// - Brown-out flag and hold bit are 0 at power-up and survive non-power-on resets.
// - Hardware clears the arm bit, sets the hold bit, sets and clears the brown-out flag.
// - A reset-control flag shows deep sleep occurred and is freely writable.
// - The power-on wake flag may set even outside deep sleep.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "dsc_regs.vh"

module dsc_deep_sleep_ctrl #(
    parameter PIN_W = 16
) (
    input  wire                   REF_CLK,
    input  wire                   RESET,
    input  wire                   SYS_RESET_PULSE,
    input  wire [`DSC_ADDR_W-1:0] ADDR,
    input  wire [`DSC_DATA_W-1:0] WDATA,
    input  wire                   WR_STB,
    input  wire                   RD_STB,
    output reg  [`DSC_DATA_W-1:0] RDATA,
    input  wire                   SLEEP_REQ,
    input  wire                   EV_PIN_CHANGE,
    input  wire                   EV_FAULT,
    input  wire                   EV_WATCHDOG,
    input  wire                   EV_CLOCK_ALARM,
    input  wire                   EV_MASTER_CLEAR,
    input  wire                   EV_POWER_ON,
    input  wire                   EV_BROWNOUT,
    input  wire                   EV_WAKE_IRQ,
    input  wire [PIN_W-1:0]       PIN_DIRECTION_REG,
    input  wire [PIN_W-1:0]       PIN_LATCH_REG,
    output reg  [PIN_W-1:0]       PIN_OUT,
    output reg  [PIN_W-1:0]       PIN_OE,
    output reg                    IN_SLEEP,
    output reg                    IN_DEEP_SLEEP,
    output reg                    PROG_MEM_POWER_DOWN,
    output reg                    REGULATOR_STANDBY,
    output reg                    IRQ
);

    localparam ST_RUN   = 3'b001;
    localparam ST_SLEEP = 3'b010;
    localparam ST_DEEP  = 3'b100;

    reg [2:0]             state_q;
    reg [2:0]             state_d;
    reg                   arm_q;
    reg                   hold_q;
    reg                   bor_q;
    reg                   bor_en_q;
    reg [`DSC_DATA_W-1:0] wake_q;
    reg                   deep_flag_q;
    reg                   program_memory_sleep_power_q;
    reg [`DSC_IRQ_W-1:0]  irq_stat_q;
    reg [`DSC_IRQ_W-1:0]  irq_mask_q;
    reg                   armed_last_q;
    reg                   arm_d;
    reg                   hold_d;
    reg                   bor_d;
    reg                   bor_en_d;
    reg [`DSC_DATA_W-1:0] wake_set;
    reg [`DSC_IRQ_W-1:0]  irq_ev;
    reg [`DSC_IRQ_W-1:0]  irq_stat_d;
    reg [`DSC_IRQ_W-1:0]  irq_mask_d;
    reg [`DSC_DATA_W-1:0] rdata_d;
    reg [PIN_W-1:0]       pin_out_d;
    reg [PIN_W-1:0]       pin_oe_d;

    // one decoder shared by every register strobe
    function dsc_hit;
        input                   stb;
        input [`DSC_ADDR_W-1:0] adr;
        input [`DSC_ADDR_W-1:0] off;
        begin
            dsc_hit = stb && (adr == off);
        end
    endfunction

    // places a single flag at its bit position in a register word
    function [`DSC_DATA_W-1:0] dsc_bit;
        input         v;
        input integer pos;
        begin
            dsc_bit      = `DSC_ZERO16;
            dsc_bit[pos] = v;
        end
    endfunction

    wire wr_ctrl = dsc_hit(WR_STB, ADDR, `DSC_OFF_CTRL);
    wire wr_wake = dsc_hit(WR_STB, ADDR, `DSC_OFF_WAKE);
    wire wr_rctl = dsc_hit(WR_STB, ADDR, `DSC_OFF_RCTL);
    wire wr_pwr  = dsc_hit(WR_STB, ADDR, `DSC_OFF_PWR);
    wire wr_mask = dsc_hit(WR_STB, ADDR, `DSC_OFF_IRQ_MASK);
    wire rd_stat = dsc_hit(RD_STB, ADDR, `DSC_OFF_IRQ_STAT);

    // brown-out never counts as a wake cause
    wire any_wake = EV_PIN_CHANGE | EV_FAULT | EV_WATCHDOG | EV_CLOCK_ALARM |
                    EV_MASTER_CLEAR | EV_POWER_ON | EV_WAKE_IRQ;

    // the arm only counts if no register access or other sleep request comes between setting it and the sleep request
    wire deep_go  = SLEEP_REQ && arm_q && armed_last_q;
    wire enter_dp = (state_q == ST_RUN) && deep_go && !SYS_RESET_PULSE;
    // a non-power-on reset also ends deep sleep, so the arm is cleared then too
    wire leave_dp = (state_q == ST_DEEP) && (any_wake || SYS_RESET_PULSE);
    wire bor_hit  = (state_q == ST_DEEP) && EV_BROWNOUT && bor_en_q;

    function [`DSC_DATA_W-1:0] dsc_ctrl_word;
        input a;
        input b;
        input h;
        begin
            dsc_ctrl_word = `DSC_ZERO16;
            dsc_ctrl_word[`DSC_CTRL_ARM]  = a;
            dsc_ctrl_word[`DSC_CTRL_BOR]  = b;
            dsc_ctrl_word[`DSC_CTRL_HOLD] = h;
        end
    endfunction

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (deep_go)
                    state_d = ST_DEEP;
                else if (SLEEP_REQ)
                    state_d = ST_SLEEP;
            end
            ST_SLEEP: begin
                if (any_wake)
                    state_d = ST_RUN;
            end
            ST_DEEP: begin
                if (any_wake)
                    state_d = ST_RUN;
            end
            default: state_d = ST_RUN;
        endcase
        // keeps the state outputs in line with the register on a non-power-on reset
        if (SYS_RESET_PULSE)
            state_d = ST_RUN;
    end

    // non-power-on resets return the state machine to run but spare the retained bits
    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            state_q <= ST_RUN;
        end else if (SYS_RESET_PULSE) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            armed_last_q <= 1'b0;
        end else begin
            armed_last_q <= (wr_ctrl && WDATA[`DSC_CTRL_ARM]) ||
                            (armed_last_q && !WR_STB && !RD_STB && !SLEEP_REQ);
        end
    end

    always @* begin
        arm_d    = arm_q;
        hold_d   = hold_q;
        bor_d    = bor_q;
        bor_en_d = bor_en_q;
        if (wr_pwr)
            bor_en_d = WDATA[`DSC_PWR_BOREN];
        if (leave_dp)
            arm_d = 1'b0;
        else if (wr_ctrl)
            arm_d = WDATA[`DSC_CTRL_ARM];
        if (enter_dp)
            hold_d = 1'b1;
        else if (wr_ctrl)
            hold_d = WDATA[`DSC_CTRL_HOLD];
        // gated brown-out flag
        // a stale flag from an earlier round is dropped as a new deep sleep starts
        if (bor_hit)
            bor_d = 1'b1;
        else if (enter_dp)
            bor_d = 1'b0;
        else if (wr_ctrl)
            bor_d = WDATA[`DSC_CTRL_BOR];
    end

    // power-on only reset
    // retained bits see only the power-on reset, never SYS_RESET_PULSE
    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            arm_q    <= 1'b0;
            hold_q   <= 1'b0;
            bor_q    <= 1'b0;
            bor_en_q <= 1'b0;
        end else begin
            arm_q    <= arm_d;
            hold_q   <= hold_d;
            bor_q    <= bor_d;
            bor_en_q <= bor_en_d;
        end
    end

    always @* begin
        wake_set = `DSC_ZERO16;
        if (state_q == ST_DEEP) begin
            wake_set = dsc_bit(EV_PIN_CHANGE, `DSC_WK_PINCHG)
                     | dsc_bit(EV_FAULT, `DSC_WK_FAULT)
                     | dsc_bit(EV_WATCHDOG, `DSC_WK_WDT)
                     | dsc_bit(EV_CLOCK_ALARM, `DSC_WK_ALARM)
                     | dsc_bit(EV_MASTER_CLEAR, `DSC_WK_MCLR);
        end
        // the power-on flag is the only one allowed to set outside deep sleep
        wake_set = wake_set | dsc_bit(EV_POWER_ON, `DSC_WK_POR);
    end

    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            wake_q <= `DSC_ZERO16;
        end else begin
            // a flag raised in the same cycle as a software write survives it
            wake_q <= (wr_wake ? (WDATA & `DSC_WK_IMPL) : wake_q) | wake_set;
        end
    end

    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            deep_flag_q <= 1'b0;
            program_memory_sleep_power_q     <= 1'b0;
        end else begin
            if (leave_dp)
                deep_flag_q <= 1'b1;
            else if (wr_rctl)
                deep_flag_q <= WDATA[`DSC_RC_DEEP];
            if (wr_rctl)
                program_memory_sleep_power_q <= WDATA[`DSC_RC_PROGRAM_MEMORY_SLEEP_POWER];
        end
    end

    // status is clear-on-read; a new event in the read cycle wins
    always @* begin
        irq_ev                 = `DSC_ZERO3;
        irq_ev[`DSC_IRQ_ENTER] = enter_dp;
        irq_ev[`DSC_IRQ_WAKE]  = leave_dp;
        irq_ev[`DSC_IRQ_BOR]   = bor_hit;
        irq_stat_d = (rd_stat ? `DSC_ZERO3 : irq_stat_q) | irq_ev;
        irq_mask_d = wr_mask ? WDATA[`DSC_IRQ_W-1:0] : irq_mask_q;
    end

    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            irq_stat_q <= `DSC_ZERO3;
            irq_mask_q <= `DSC_ZERO3;
            IRQ        <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            // built from the next values so IRQ lines up with the status it reports
            IRQ        <= |(irq_stat_d & irq_mask_d);
        end
    end

    always @* begin
        rdata_d = `DSC_ZERO16;
        if (RD_STB) begin
            case (ADDR)
                `DSC_OFF_CTRL:     rdata_d = dsc_ctrl_word(arm_q, bor_q, hold_q);
                `DSC_OFF_WAKE:     rdata_d = wake_q;
                `DSC_OFF_RCTL:     rdata_d = dsc_bit(deep_flag_q, `DSC_RC_DEEP)
                                           | dsc_bit(program_memory_sleep_power_q, `DSC_RC_PROGRAM_MEMORY_SLEEP_POWER);
                `DSC_OFF_PWR:      rdata_d = dsc_bit(bor_en_q, `DSC_PWR_BOREN);
                `DSC_OFF_IRQ_STAT: rdata_d = {{(`DSC_DATA_W-`DSC_IRQ_W){1'b0}}, irq_stat_q};
                `DSC_OFF_IRQ_MASK: rdata_d = {{(`DSC_DATA_W-`DSC_IRQ_W){1'b0}}, irq_mask_q};
                default:           rdata_d = `DSC_ZERO16;
            endcase
        end
    end

    // read data stands for one cycle only, then returns to zero
    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            RDATA <= `DSC_ZERO16;
        end else begin
            RDATA <= rdata_d;
        end
    end

    // pin hold
    // frozen copy stays as it was; only released pins follow the latch and direction
    always @* begin
        pin_out_d = PIN_OUT;
        pin_oe_d  = PIN_OE;
        // the entry cycle is excluded too, so pins freeze on the edge that enters
        if (!hold_q && !enter_dp) begin
            pin_out_d = PIN_LATCH_REG;
            pin_oe_d  = ~PIN_DIRECTION_REG;
        end
    end

    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            PIN_OUT <= {PIN_W{1'b0}};
            PIN_OE  <= {PIN_W{1'b0}};
        end else begin
            PIN_OUT <= pin_out_d;
            PIN_OE  <= pin_oe_d;
        end
    end

    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            IN_SLEEP            <= 1'b0;
            IN_DEEP_SLEEP       <= 1'b0;
            PROG_MEM_POWER_DOWN <= 1'b0;
            REGULATOR_STANDBY   <= 1'b0;
        end else begin
            IN_SLEEP            <= (state_d == ST_SLEEP);
            IN_DEEP_SLEEP       <= (state_d == ST_DEEP);
            PROG_MEM_POWER_DOWN <= (state_d == ST_DEEP) || ((state_d == ST_SLEEP) && !program_memory_sleep_power_q);
            REGULATOR_STANDBY   <= PROG_MEM_POWER_DOWN;
        end
    end

endmodule

// *** include/dsc_regs.vh ***
// Purpose: register map and constants for the deep-sleep control block
// Assumes: 16-bit registers reached by word index on a plain strobe port
// Notes:   offsets are local indices; bit positions follow the register layout
`ifndef DSC_REGS_VH
`define DSC_REGS_VH

`define DSC_ADDR_W        4
`define DSC_DATA_W        16

`define DSC_OFF_CTRL      4'h0
`define DSC_OFF_WAKE      4'h1
`define DSC_OFF_RCTL      4'h2
`define DSC_OFF_PWR       4'h3
`define DSC_OFF_IRQ_STAT  4'h4
`define DSC_OFF_IRQ_MASK  4'h5

// control register fields
`define DSC_CTRL_ARM      15
`define DSC_CTRL_BOR      1
`define DSC_CTRL_HOLD     0

// wake-source fields
`define DSC_WK_PINCHG     8
`define DSC_WK_FAULT      7
`define DSC_WK_WDT        4
`define DSC_WK_ALARM      3
`define DSC_WK_MCLR       2
`define DSC_WK_POR        0
`define DSC_WK_IMPL       16'h0000_019D

// reset-control fields
`define DSC_RC_DEEP       10
`define DSC_RC_PROGRAM_MEMORY_SLEEP_POWER      8

// interrupt status fields
`define DSC_IRQ_ENTER     0
`define DSC_IRQ_WAKE      1
`define DSC_IRQ_BOR       2
`define DSC_IRQ_W         3

// power-control fields
`define DSC_PWR_BOREN     0

`define DSC_ZERO16        16'h0000
`define DSC_ZERO3         3'h0

`endif

// *** sim/dsc_deep_sleep_ctrl_bench.sv ***
// Purpose: register-level test of the deep-sleep control block
// Assumes: reads return data one cycle after the strobe
// Notes:   each deep-sleep round uses one wake cause
`timescale 1ns/1ps
`include "dsc_regs.vh"
module dsc_deep_sleep_ctrl_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wst = 1'b0;
    logic        rds = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic [9:0]  st = 10'h000;
    logic [15:0] pdir = 16'h00FF;
    logic [15:0] plat = 16'hA5A5;
    logic [15:0] rdata, pout, poe, old;
    logic        in_slp, in_deep, pmd, stby, irq, boe;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          pos [6] = '{0, 2, 3, 4, 7, 8};
    always #4 clk = ~clk;
    dsc_deep_sleep_ctrl #(.PIN_W(16)) i_dut (.REF_CLK(clk), .RESET(rst),
        .SYS_RESET_PULSE(st[9]), .ADDR(addr), .WDATA(wdata), .WR_STB(wst), .RD_STB(rds),
        .RDATA(rdata), .SLEEP_REQ(st[8]), .EV_WAKE_IRQ(st[7]), .EV_BROWNOUT(st[6]),
        .EV_PIN_CHANGE(st[5]), .EV_FAULT(st[4]), .EV_WATCHDOG(st[3]), .EV_CLOCK_ALARM(st[2]),
        .EV_MASTER_CLEAR(st[1]), .EV_POWER_ON(st[0]), .PIN_DIRECTION_REG(pdir),
        .PIN_LATCH_REG(plat), .PIN_OUT(pout), .PIN_OE(poe), .IN_SLEEP(in_slp),
        .IN_DEEP_SLEEP(in_deep), .PROG_MEM_POWER_DOWN(pmd), .REGULATOR_STANDBY(stby), .IRQ(irq));
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wst <= 1'b1;
        @(posedge clk);
        wst <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] e, input string nm);
        @(posedge clk);
        addr <= a;
        rds <= 1'b1;
        @(posedge clk);
        rds <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask
    // one-cycle pulse on {sys reset, sleep, events}
    task pulse(input logic [9:0] s);
        @(posedge clk);
        st <= s;
        @(posedge clk);
        st <= 10'h000;
        #1;
    endtask
    task close_out;
        if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(`DSC_OFF_CTRL, 16'h0000, "ctrl_por");
        wr(`DSC_OFF_CTRL, 16'hFFFF);
        rd(`DSC_OFF_CTRL, 16'h8003, "ctrl_rw");
        wr(4'hF, 16'hFFFF);
        rd(4'hF, 16'h0000, "unmapped");
        wr(`DSC_OFF_CTRL, 16'h0000);
        pulse(10'h03E);
        rd(`DSC_OFF_WAKE, 16'h0000, "wake_awake");
        pulse(10'h001);
        rd(`DSC_OFF_WAKE, 16'h0001, "por_awake");
        wr(`DSC_OFF_WAKE, 16'h0000);
        wr(`DSC_OFF_RCTL, 16'h0000);
        for (int k = 0; k < 6; k++) begin
            boe = (k != 0);
            wr(`DSC_OFF_PWR, {15'h0000, boe});
            wr(`DSC_OFF_IRQ_MASK, (k == 1) ? 16'h0000 : 16'h0007);
            wr(`DSC_OFF_CTRL, 16'h8000);
            pulse(10'h100);
            chk("deep", 16'h0001, {14'h0000, in_slp, in_deep});
            chk("pmem_down", 16'h0001, {15'h0000, pmd});
            old = plat;
            plat <= ~plat;
            pulse(10'h040);
            chk("bor_stay", 16'h0001, {15'h0000, in_deep});
            chk("pin_held", old, pout);
            chk("stby_deep", 16'h0001, {15'h0000, stby});
            pulse(10'h001 << k);
            chk("woke", 16'h0000, {15'h0000, in_deep});
            pulse(10'h200);
            rd(`DSC_OFF_CTRL, {14'h0000, boe, 1'b1}, "ctrl_after");
            rd(`DSC_OFF_WAKE, 16'h0001 << pos[k], "wake_src");
            rd(`DSC_OFF_RCTL, (k == 0) ? 16'h0400 : 16'h0500, "deep_seen");
            chk("irq", {15'h0000, k != 1}, {15'h0000, irq});
            rd(`DSC_OFF_IRQ_STAT, {13'h0000, boe, 2'b11}, "irq_stat");
            chk("irq_clr", 16'h0000, {15'h0000, irq});
            wr(`DSC_OFF_CTRL, 16'h0000);
            wr(`DSC_OFF_WAKE, 16'h0000);
            chk("pin_free", ~old, pout);
            chk("pin_oe", ~pdir, poe);
            wr(`DSC_OFF_RCTL, 16'h0100);
        end
        wr(`DSC_OFF_CTRL, 16'h8000);
        rd(`DSC_OFF_CTRL, 16'h8000, "armed");
        pulse(10'h100);
        chk("late_sleep", 16'h0002, {14'h0000, in_slp, in_deep});
        chk("pmem_kept", 16'h0000, {15'h0000, pmd});
        pulse(10'h080);
        chk("slp_woke", 16'h0000, {14'h0000, in_slp, in_deep});
        wr(`DSC_OFF_RCTL, 16'h0000);
        pulse(10'h100);
        chk("pmem_off", 16'h0003, {14'h0000, in_slp, pmd});
        pulse(10'h080);
        close_out();
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        close_out();
    end
endmodule
bind dsc_deep_sleep_ctrl dsc_deep_sleep_ctrl_chk #(.PIN_W(PIN_W)) u_chk (.REF_CLK, .RESET,
    .SYS_RESET_PULSE, .ADDR, .WDATA, .WR_STB, .RD_STB, .RDATA, .SLEEP_REQ, .EV_PIN_CHANGE,
    .EV_FAULT, .EV_WATCHDOG, .EV_CLOCK_ALARM, .EV_MASTER_CLEAR, .EV_POWER_ON, .EV_BROWNOUT,
    .EV_WAKE_IRQ, .PIN_OUT, .IN_SLEEP, .IN_DEEP_SLEEP, .PROG_MEM_POWER_DOWN,
    .REGULATOR_STANDBY);

// *** sim/dsc_deep_sleep_ctrl_sva.sv ***
// Purpose: port-level assertions for the deep-sleep control block
// Assumes: one clock; RESET is the asynchronous power-on reset
// Notes:   wake causes are excluded from the entry check on purpose
`timescale 1ns/1ps
`include "dsc_regs.vh"
module dsc_deep_sleep_ctrl_chk #(parameter PIN_W = 16) (
    input logic                   REF_CLK,
    input logic                   RESET,
    input logic                   SYS_RESET_PULSE,
    input logic [`DSC_ADDR_W-1:0] ADDR,
    input logic [`DSC_DATA_W-1:0] WDATA,
    input logic                   WR_STB,
    input logic                   RD_STB,
    input logic [`DSC_DATA_W-1:0] RDATA,
    input logic                   SLEEP_REQ,
    input logic                   EV_PIN_CHANGE,
    input logic                   EV_FAULT,
    input logic                   EV_WATCHDOG,
    input logic                   EV_CLOCK_ALARM,
    input logic                   EV_MASTER_CLEAR,
    input logic                   EV_POWER_ON,
    input logic                   EV_BROWNOUT,
    input logic                   EV_WAKE_IRQ,
    input logic [PIN_W-1:0]       PIN_OUT,
    input logic                   IN_SLEEP,
    input logic                   IN_DEEP_SLEEP,
    input logic                   PROG_MEM_POWER_DOWN,
    input logic                   REGULATOR_STANDBY
);
    logic wk;
    // brown-out is left out: it must never wake
    assign wk = EV_PIN_CHANGE | EV_FAULT | EV_WATCHDOG | EV_CLOCK_ALARM
              | EV_MASTER_CLEAR | EV_POWER_ON | EV_WAKE_IRQ;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    sequence s_arm;
        WR_STB && ADDR == `DSC_OFF_CTRL && WDATA[`DSC_CTRL_ARM] && !IN_SLEEP && !IN_DEEP_SLEEP;
    endsequence
    sequence s_go;
        SLEEP_REQ && !WR_STB && !RD_STB && !wk && !SYS_RESET_PULSE;
    endsequence
    property p_deep_entry; s_arm ##1 s_go |=> IN_DEEP_SLEEP; endproperty
    property p_bor_stay;
        IN_DEEP_SLEEP && EV_BROWNOUT && !wk && !SYS_RESET_PULSE |=> IN_DEEP_SLEEP;
    endproperty
    property p_wake; IN_DEEP_SLEEP && wk |=> !IN_DEEP_SLEEP; endproperty
    property p_hold; IN_DEEP_SLEEP |=> $stable(PIN_OUT); endproperty
    property p_rd_unimpl; RD_STB && ADDR == `DSC_OFF_CTRL |=> RDATA[14:2] == 13'h0000; endproperty
    property p_rd_idle; !RD_STB |=> RDATA == 16'h0000; endproperty
    property p_stby; REGULATOR_STANDBY == $past(PROG_MEM_POWER_DOWN); endproperty
    property p_pmd_deep; IN_DEEP_SLEEP |-> PROG_MEM_POWER_DOWN; endproperty
    a_deep_entry: assert property (p_deep_entry) else $error("deep sleep not entered");
    a_bor_stay: assert property (p_bor_stay) else $error("brown-out woke the device");
    a_wake: assert property (p_wake) else $error("wake cause ignored");
    a_hold: assert property (p_hold) else $error("pins moved in deep sleep");
    a_rd_unimpl: assert property (p_rd_unimpl) else $error("unused control bits set");
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    a_stby: assert property (p_stby) else $error("standby not following power-down");
    a_pmd_deep: assert property (p_pmd_deep) else $error("memory powered in deep sleep");
endmodule
